//--- test/stib_host_model.sv
`timescale 1ns/1ps
module stib_host_model (
    input  wire logic clk,
    output logic      csn_pin,
    output logic      sclk_pin,
    output logic      si_pin,
    input  wire logic so
);
    logic [7:0] wbuf [16];
    logic [7:0] rd_byte;
    event       rd_done;

    initial begin
        csn_pin  = 1'b1;
        sclk_pin = 1'b0;
        si_pin   = 1'b1;
        foreach (wbuf[i]) begin
            wbuf[i] = 8'h00;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Five clocks per level leaves margin over the four-clock sampling floor
    task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sclk_pin = 1'b0;
            si_pin   = b[i];
            tick(5);
            sclk_pin = 1'b1;
            r[i]     = so;
            tick(5);
        end
    endtask : shift_byte

    task automatic xfer(input logic [7:0] hdr, input int n);
        logic [7:0] r;
        csn_pin = 1'b0;
        tick(5);
        shift_byte(hdr, r);
        for (int k = 0; k < n; k++) begin
            shift_byte(wbuf[k], r);
            if (hdr[7]) begin
                rd_byte = r;
                -> rd_done;
            end
        end
        sclk_pin = 1'b0;
        tick(5);
        csn_pin = 1'b1;
        // Released data line must not keep its last level
        si_pin = ~si_pin;
        tick(8);
    endtask : xfer
endmodule : stib_host_model

//--- test/stib_reg_bank_props.sv
`timescale 1ns/1ps
module stib_reg_bank_props (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       csn_pin,
    input wire logic       so_oe_n,
    input wire logic       sleep_active,
    input wire logic       radio_idle,
    input wire logic       converter_hold_in_sleep,
    input wire logic       cal_result_valid,
    input wire logic [5:0] cal_coarse_result,
    input wire logic [5:0] vco_coarse_cap_cal,
    input wire logic       cal_override_load,
    input wire logic [7:0] synth_test,
    input wire logic [7:0] production_test,
    input wire logic [7:0] gain_ctrl_test,
    input wire logic [7:0] analog_test_a_int,
    input wire logic [7:0] analog_test_b_int,
    input wire logic [7:0] analog_test_c,
    input wire logic       osc_select_cal_stage_on,
    input wire logic       temp_sensor_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_temp_follows_idle: assert property (1'b1 |=>
        temp_sensor_en == $past(radio_idle && production_test == 8'hbf))
        else $error("temperature enable does not follow idle and 0xbf");
    chk_osc_stage_bit: assert property (osc_select_cal_stage_on == analog_test_c[1])
        else $error("select stage enable differs from bit 1");
    chk_wake_held_copy: assert property ($fell(sleep_active) && converter_hold_in_sleep |=>
        analog_test_a_int == 8'h81 && analog_test_b_int == 8'h35)
        else $error("held wake copies wrong");
    chk_wake_plain_copy: assert property ($fell(sleep_active) && !converter_hold_in_sleep |=>
        analog_test_a_int == 8'h88 && analog_test_b_int == 8'h31)
        else $error("plain wake copies wrong");
    chk_wake_group_values: assert property ($fell(sleep_active) |=>
        synth_test == 8'h59 && production_test == 8'h7f && gain_ctrl_test == 8'h3f && analog_test_c == 8'h0b)
        else $error("test group not restored at wake");
    chk_override_one_cycle: assert property (cal_override_load |=> !cal_override_load)
        else $error("override load longer than one cycle");
    // A host write in the same cycle wins and shows as the override pulse
    chk_engine_result_load: assert property (cal_result_valid |=>
        cal_override_load || vco_coarse_cap_cal == $past(cal_coarse_result))
        else $error("engine result not loaded");
    chk_override_on_write: assert property ($changed(vco_coarse_cap_cal)
        && !$past(cal_result_valid) |-> cal_override_load)
        else $error("host load of coarse cap without override pulse");
    chk_so_release_idle: assert property (csn_pin [*6] |=> so_oe_n)
        else $error("serial output driven while deselected");
    chk_so_drive_frame: assert property (!csn_pin [*6] |=> !so_oe_n)
        else $error("serial output not driven in frame");
endmodule : stib_reg_bank_props

bind stib_reg_bank stib_reg_bank_props u_props (.clk(clk), .reset_n(reset_n), .csn_pin(csn_pin), .so_oe_n(so_oe_n),
    .sleep_active(sleep_active), .radio_idle(radio_idle), .converter_hold_in_sleep(converter_hold_in_sleep),
    .cal_result_valid(cal_result_valid), .cal_coarse_result(cal_coarse_result),
    .vco_coarse_cap_cal(vco_coarse_cap_cal), .cal_override_load(cal_override_load), .synth_test(synth_test),
    .production_test(production_test), .gain_ctrl_test(gain_ctrl_test), .analog_test_a_int(analog_test_a_int),
    .analog_test_b_int(analog_test_b_int), .analog_test_c(analog_test_c),
    .osc_select_cal_stage_on(osc_select_cal_stage_on), .temp_sensor_en(temp_sensor_en));

//--- test/test_synth_test_id_register_bank.sv
`timescale 1ns/1ps
module test_synth_test_id_register_bank;
    typedef struct {string what; logic [7:0] v;} stib_note_t;
    localparam logic [7:0] PART_VAL = 8'ha7; // Arbitrary value
    localparam logic [7:0] REV_VAL  = 8'h12; // Arbitrary value
    localparam logic [5:0] WA [8]  = '{6'h25, 6'h26, 6'h27, 6'h28, 6'h2a, 6'h2c, 6'h2d, 6'h2e};
    localparam logic [7:0] WM [8]  = '{8'h3f, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0] RT [11] = '{8'h20, 8'h0d, 8'h41, 8'h00, 8'h59, 8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b, 8'h00};
    logic        clk, reset_n, csn_pin, sclk_pin, si_pin, so, so_oe_n;
    logic        sleep_active, radio_idle, converter_hold_in_sleep, cal_result_valid;
    logic        cal_override_load, osc_select_cal_stage_on, temp_sensor_en;
    logic [5:0]  cal_coarse_result, vco_coarse_cap_cal, ra;
    logic [6:0]  synth_cal_control, rc_osc_config_hi, rc_osc_config_lo;
    logic [7:0]  synth_test, production_test, gain_ctrl_test, analog_test_c, analog_test_a_int, analog_test_b_int;
    logic [7:0]  wv [8];
    logic [31:0] seed;
    int          fail_count, samples_checked, cycles;
    stib_note_t  exp_q [$];
    stib_note_t  e;

    stib_reg_bank #(.PART_NUMBER_VALUE(PART_VAL), .REVISION_VALUE(REV_VAL)) u_dut (
        .clk(clk), .reset_n(reset_n), .csn_pin(csn_pin), .sclk_pin(sclk_pin), .si_pin(si_pin), .so(so),
        .so_oe_n(so_oe_n), .sleep_active(sleep_active), .radio_idle(radio_idle),
        .converter_hold_in_sleep(converter_hold_in_sleep), .cal_result_valid(cal_result_valid),
        .cal_coarse_result(cal_coarse_result), .vco_coarse_cap_cal(vco_coarse_cap_cal),
        .cal_override_load(cal_override_load), .synth_cal_control(synth_cal_control),
        .rc_osc_config_hi(rc_osc_config_hi), .rc_osc_config_lo(rc_osc_config_lo), .synth_test(synth_test),
        .production_test(production_test), .gain_ctrl_test(gain_ctrl_test), .analog_test_a_int(analog_test_a_int),
        .analog_test_b_int(analog_test_b_int), .analog_test_c(analog_test_c),
        .osc_select_cal_stage_on(osc_select_cal_stage_on), .temp_sensor_en(temp_sensor_en));

    stib_host_model u_host (.clk(clk), .csn_pin(csn_pin), .sclk_pin(sclk_pin), .si_pin(si_pin), .so(so));

    always #25 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_host.wbuf[0] = d;
        u_host.xfer({2'b00, a}, 1);
    endtask : wr

    task automatic rd(input logic [7:0] h, input logic [7:0] v, input string w);
        exp_q.push_back('{w, v});
        u_host.xfer(h, 1);
    endtask : rd

    task automatic cal_pulse(input logic [5:0] r);
        cal_coarse_result = r;
        cal_result_valid  = 1'b1;
        tick(1);
        cal_result_valid  = 1'b0;
        tick(2);
    endtask : cal_pulse

    always begin
        @(u_host.rd_done);
        e = exp_q.pop_front();
        check(e.what, u_host.rd_byte, e.v);
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        sleep_active = 1'b0;
        radio_idle = 1'b0;
        converter_hold_in_sleep = 1'b0;
        cal_result_valid = 1'b0;
        cal_coarse_result = 6'h00;
        seed = 32'h9d43;
        tick(2);
        reset_n = 1'b1;
        tick(4);
        for (int i = 0; i < 11; i++) begin
            exp_q.push_back('{"reset value", RT[i]});
        end
        u_host.xfer(8'he5, 11);
        seed = xs(seed);
        ra = seed[5:0];
        cal_pulse(ra);
        rd(8'ha5, {2'b00, ra}, "saved cal");
        cal_pulse(~ra);
        wr(6'h25, {2'b11, ra});
        check("coarse cap", {2'b00, vco_coarse_cap_cal}, {2'b00, ra});
        // Unused bits written as ones to prove they are dropped
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wv[i] = seed[7:0] | ~WM[i];
            wr(WA[i], wv[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd({2'b10, WA[i]}, wv[i] & WM[i], "readback");
        end
        check("cal control", {1'b0, synth_cal_control}, wv[1] & 8'h7f);
        check("rc hi", {1'b0, rc_osc_config_hi}, wv[2] & 8'h7f);
        check("rc lo", {1'b0, rc_osc_config_lo}, wv[3] & 8'h7f);
        check("osc stage", {7'h00, osc_select_cal_stage_on}, {7'h00, wv[7][1]});
        radio_idle = 1'b1;
        wr(6'h2a, 8'hbf);
        tick(2);
        check("temp on", {7'h00, temp_sensor_en}, 8'h01);
        radio_idle = 1'b0;
        tick(2);
        check("temp off", {7'h00, temp_sensor_en}, 8'h00);
        wr(6'h2a, 8'h7f);
        for (int h = 1; h >= 0; h--) begin
            wr(6'h2c, 8'h5c);
            wr(6'h2d, 8'h5c);
            wr(6'h2e, 8'h00);
            converter_hold_in_sleep = h[0];
            sleep_active = 1'b1;
            tick(3);
            sleep_active = 1'b0;
            tick(2);
            check("copy a", analog_test_a_int, h[0] ? 8'h81 : 8'h88);
            check("copy b", analog_test_b_int, h[0] ? 8'h35 : 8'h31);
            rd(8'hac, 8'h88, "test a");
            rd(8'had, 8'h31, "test b");
            rd(8'hae, 8'h0b, "test c");
        end
        rd(8'hf1, REV_VAL, "revision");
        wr(6'h30, 8'h00);
        wr(6'h2f, 8'hff);
        rd(8'haf, 8'h00, "unmapped");
        exp_q.push_back('{"part number", PART_VAL});
        exp_q.push_back('{"part number", PART_VAL});
        u_host.xfer(8'hf0, 2);
        tick(2);
        end_sim();
    end
endmodule : test_synth_test_id_register_bank

//--- verilog/stib_acc_if.sv
`timescale 1ns/1ps
interface stib_acc_if;
    logic       wr_stb;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd_data;

    modport master (output wr_stb, output addr, output wdata, input rd_data);
    modport bank   (input wr_stb, input addr, input wdata, output rd_data);
endinterface : stib_acc_if

//--- verilog/stib_pkg.sv
package stib_pkg;

    // Register offsets on the serial register port (6-bit address field)
    localparam logic [5:0] ADDR_VCO_COARSE_CAP_CAL  = 6'h25;
    localparam logic [5:0] ADDR_SYNTH_CAL_CONTROL   = 6'h26;
    localparam logic [5:0] ADDR_RC_OSC_CONFIG_HI    = 6'h27;
    localparam logic [5:0] ADDR_RC_OSC_CONFIG_LO    = 6'h28;
    localparam logic [5:0] ADDR_SYNTH_TEST          = 6'h29;
    localparam logic [5:0] ADDR_PRODUCTION_TEST     = 6'h2a;
    localparam logic [5:0] ADDR_GAIN_CTRL_TEST      = 6'h2b;
    localparam logic [5:0] ADDR_ANALOG_TEST_A       = 6'h2c;
    localparam logic [5:0] ADDR_ANALOG_TEST_B       = 6'h2d;
    localparam logic [5:0] ADDR_ANALOG_TEST_C       = 6'h2e;
    localparam logic [5:0] ADDR_PART_NUMBER_ID      = 6'h30;
    localparam logic [5:0] ADDR_SILICON_REVISION_ID = 6'h31;
    localparam logic [5:0] ADDR_STATUS_BASE         = 6'h30;

    // Header byte layout
    localparam int HDR_READ_BIT  = 7;
    localparam int HDR_BURST_BIT = 6;

    // Implemented bits of the calibration and oscillator registers
    localparam logic [7:0] MASK_6BIT = 8'h3f;
    localparam logic [7:0] MASK_7BIT = 8'h7f;

    // Values after reset
    localparam logic [7:0] RST_VCO_COARSE_CAP_CAL = 8'h20;
    localparam logic [7:0] RST_SYNTH_CAL_CONTROL  = 8'h0d;
    localparam logic [7:0] RST_RC_OSC_CONFIG_HI   = 8'h41;
    localparam logic [7:0] RST_RC_OSC_CONFIG_LO   = 8'h00;
    localparam logic [7:0] RST_SYNTH_TEST         = 8'h59;
    localparam logic [7:0] RST_PRODUCTION_TEST    = 8'h7f;
    localparam logic [7:0] RST_GAIN_CTRL_TEST     = 8'h3f;
    localparam logic [7:0] RST_ANALOG_TEST_A      = 8'h88;
    localparam logic [7:0] RST_ANALOG_TEST_B      = 8'h31;
    localparam logic [7:0] RST_ANALOG_TEST_C      = 8'h0b;

    // Internal analog copies forced at wake-up when the converter holds its state
    localparam logic [7:0] WAKE_ANALOG_A_HOLD = 8'h81;
    localparam logic [7:0] WAKE_ANALOG_B_HOLD = 8'h35;

    localparam logic [7:0] TEMP_SENSOR_ENABLE = 8'hbf;
    localparam int         OSC_SEL_CAL_BIT    = 1;

endpackage : stib_pkg

//--- verilog/stib_reg_bank.sv
`timescale 1ns/1ps
module stib_reg_bank
    import stib_pkg::*;
#(
    // Arbitrary identity values
    parameter logic [7:0] PART_NUMBER_VALUE = 8'h5a,
    parameter logic [7:0] REVISION_VALUE    = 8'h03
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  csn_pin,
    input  wire logic  sclk_pin,
    input  wire logic  si_pin,
    output logic       so,
    output logic       so_oe_n,
    input  wire logic  sleep_active,
    input  wire logic  radio_idle,
    input  wire logic  converter_hold_in_sleep,
    input  wire logic  cal_result_valid,
    input  wire logic [5:0] cal_coarse_result,
    output logic [5:0] vco_coarse_cap_cal,
    output logic       cal_override_load,
    output logic [6:0] synth_cal_control,
    output logic [6:0] rc_osc_config_hi,
    output logic [6:0] rc_osc_config_lo,
    output logic [7:0] synth_test,
    output logic [7:0] production_test,
    output logic [7:0] gain_ctrl_test,
    output logic [7:0] analog_test_a_int,
    output logic [7:0] analog_test_b_int,
    output logic [7:0] analog_test_c,
    output logic       osc_select_cal_stage_on,
    output logic       temp_sensor_en
);

    function automatic logic [7:0] keep_bits(input logic [7:0] value, input logic [7:0] mask);
        keep_bits = value & mask;
    endfunction : keep_bits

    stib_acc_if acc ();

    logic       so_w;
    logic       so_oe_n_w;
    logic [7:0] vco_coarse_cap_cal_r;
    logic [7:0] synth_cal_control_r;
    logic [7:0] rc_osc_config_hi_r;
    logic [7:0] rc_osc_config_lo_r;
    logic [7:0] synth_test_r;
    logic [7:0] production_test_r;
    logic [7:0] gain_ctrl_test_r;
    logic [7:0] analog_test_a_r;
    logic [7:0] analog_test_b_r;
    logic [7:0] analog_test_c_r;
    logic [7:0] analog_a_int_r;
    logic [7:0] analog_b_int_r;
    logic       sleep_d_r;
    logic       cal_override_load_r;
    logic       temp_sensor_en_r;
    logic       so_r;
    logic       so_oe_n_r;
    logic [7:0] rd_data_nxt;

    stib_spi_slave u_spi (
        .clk       (clk),
        .reset_n   (reset_n),
        .csn_pin   (csn_pin),
        .sclk_pin  (sclk_pin),
        .si_pin    (si_pin),
        .so_r      (so_w),
        .so_oe_n_r (so_oe_n_w),
        .acc       (acc.master)
    );

    // Address decode
    wire wr      = acc.wr_stb;
    wire wr_vcc  = wr & (acc.addr == ADDR_VCO_COARSE_CAP_CAL);
    wire wr_scc  = wr & (acc.addr == ADDR_SYNTH_CAL_CONTROL);
    wire wr_rch  = wr & (acc.addr == ADDR_RC_OSC_CONFIG_HI);
    wire wr_rcl  = wr & (acc.addr == ADDR_RC_OSC_CONFIG_LO);
    wire wr_st   = wr & (acc.addr == ADDR_SYNTH_TEST);
    wire wr_pt   = wr & (acc.addr == ADDR_PRODUCTION_TEST);
    wire wr_gt   = wr & (acc.addr == ADDR_GAIN_CTRL_TEST);
    wire wr_ta   = wr & (acc.addr == ADDR_ANALOG_TEST_A);
    wire wr_tb   = wr & (acc.addr == ADDR_ANALOG_TEST_B);
    wire wr_tc   = wr & (acc.addr == ADDR_ANALOG_TEST_C);
    wire wake    = sleep_d_r & ~sleep_active;

    // Internal analog copies differ from the readable value only after a held wake-up
    wire [7:0] wake_a = converter_hold_in_sleep ? WAKE_ANALOG_A_HOLD : RST_ANALOG_TEST_A;
    wire [7:0] wake_b = converter_hold_in_sleep ? WAKE_ANALOG_B_HOLD : RST_ANALOG_TEST_B;

    always_comb begin
        case (acc.addr)
            ADDR_VCO_COARSE_CAP_CAL:  rd_data_nxt = vco_coarse_cap_cal_r;
            ADDR_SYNTH_CAL_CONTROL:   rd_data_nxt = synth_cal_control_r;
            ADDR_RC_OSC_CONFIG_HI:    rd_data_nxt = rc_osc_config_hi_r;
            ADDR_RC_OSC_CONFIG_LO:    rd_data_nxt = rc_osc_config_lo_r;
            ADDR_SYNTH_TEST:          rd_data_nxt = synth_test_r;
            ADDR_PRODUCTION_TEST:     rd_data_nxt = production_test_r;
            ADDR_GAIN_CTRL_TEST:      rd_data_nxt = gain_ctrl_test_r;
            ADDR_ANALOG_TEST_A:       rd_data_nxt = analog_test_a_r;
            ADDR_ANALOG_TEST_B:       rd_data_nxt = analog_test_b_r;
            ADDR_ANALOG_TEST_C:       rd_data_nxt = analog_test_c_r;
            ADDR_PART_NUMBER_ID:      rd_data_nxt = PART_NUMBER_VALUE;
            ADDR_SILICON_REVISION_ID: rd_data_nxt = REVISION_VALUE;
            default:                  rd_data_nxt = 8'h00;
        endcase
    end

    assign acc.rd_data = rd_data_nxt;

    // Calibration and oscillator group keeps its contents through sleep
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vco_coarse_cap_cal_r <= RST_VCO_COARSE_CAP_CAL;
            synth_cal_control_r  <= RST_SYNTH_CAL_CONTROL;
            rc_osc_config_hi_r   <= RST_RC_OSC_CONFIG_HI;
            rc_osc_config_lo_r   <= RST_RC_OSC_CONFIG_LO;
            cal_override_load_r  <= 1'b0;
        end else begin
            // Host write beats a simultaneous engine result: saved values are the hop's intent
            if (wr_vcc) begin
                vco_coarse_cap_cal_r <= keep_bits(acc.wdata, MASK_6BIT);
            end else if (cal_result_valid) begin
                vco_coarse_cap_cal_r <= {2'b00, cal_coarse_result};
            end
            if (wr_scc) begin
                synth_cal_control_r <= keep_bits(acc.wdata, MASK_7BIT);
            end
            if (wr_rch) begin
                rc_osc_config_hi_r <= keep_bits(acc.wdata, MASK_7BIT);
            end
            if (wr_rcl) begin
                rc_osc_config_lo_r <= keep_bits(acc.wdata, MASK_7BIT);
            end
            cal_override_load_r <= wr_vcc;
        end
    end

    // Test group: readable defaults come back on every wake-up
    always_ff @(posedge clk) begin
        if (!reset_n || wake) begin
            synth_test_r      <= RST_SYNTH_TEST;
            production_test_r <= RST_PRODUCTION_TEST;
            gain_ctrl_test_r  <= RST_GAIN_CTRL_TEST;
            analog_test_a_r   <= RST_ANALOG_TEST_A;
            analog_test_b_r   <= RST_ANALOG_TEST_B;
            analog_test_c_r   <= RST_ANALOG_TEST_C;
        end else begin
            if (wr_st) begin
                synth_test_r <= acc.wdata;
            end
            if (wr_pt) begin
                production_test_r <= acc.wdata;
            end
            if (wr_gt) begin
                gain_ctrl_test_r <= acc.wdata;
            end
            if (wr_ta) begin
                analog_test_a_r <= acc.wdata;
            end
            if (wr_tb) begin
                analog_test_b_r <= acc.wdata;
            end
            if (wr_tc) begin
                analog_test_c_r <= acc.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            analog_a_int_r <= RST_ANALOG_TEST_A;
            analog_b_int_r <= RST_ANALOG_TEST_B;
        end else if (wake) begin
            analog_a_int_r <= wake_a;
            analog_b_int_r <= wake_b;
        end else begin
            if (wr_ta) begin
                analog_a_int_r <= acc.wdata;
            end
            if (wr_tb) begin
                analog_b_int_r <= acc.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sleep_d_r        <= 1'b0;
            temp_sensor_en_r <= 1'b0;
            so_r             <= 1'b0;
            so_oe_n_r        <= 1'b1;
        end else begin
            sleep_d_r        <= sleep_active;
            temp_sensor_en_r <= radio_idle & (production_test_r == TEMP_SENSOR_ENABLE);
            so_r             <= so_w;
            so_oe_n_r        <= so_oe_n_w;
        end
    end

    assign so                      = so_r;
    assign so_oe_n                 = so_oe_n_r;
    assign vco_coarse_cap_cal      = vco_coarse_cap_cal_r[5:0];
    assign cal_override_load       = cal_override_load_r;
    assign synth_cal_control       = synth_cal_control_r[6:0];
    assign rc_osc_config_hi        = rc_osc_config_hi_r[6:0];
    assign rc_osc_config_lo        = rc_osc_config_lo_r[6:0];
    assign synth_test              = synth_test_r;
    assign production_test         = production_test_r;
    assign gain_ctrl_test          = gain_ctrl_test_r;
    assign analog_test_a_int       = analog_a_int_r;
    assign analog_test_b_int       = analog_b_int_r;
    assign analog_test_c           = analog_test_c_r;
    assign osc_select_cal_stage_on = analog_test_c_r[OSC_SEL_CAL_BIT];
    assign temp_sensor_en          = temp_sensor_en_r;

endmodule : stib_reg_bank

//--- verilog/stib_spi_slave.sv
`timescale 1ns/1ps
module stib_spi_slave
    import stib_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  csn_pin,
    input  wire logic  sclk_pin,
    input  wire logic  si_pin,
    output logic       so_r,
    output logic       so_oe_n_r,
    stib_acc_if.master acc
);
    logic [2:0] pins_s;
    logic       csn_s;
    logic       sclk_s;
    logic       si_s;
    logic       sclk_d_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic       have_hdr_r;
    logic       read_r;
    logic       burst_r;
    logic [5:0] addr_r;
    logic       load_r;
    logic       wr_stb_r;
    logic [7:0] wdata_r;

    stib_sync2 #(.WIDTH(3)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({csn_pin, sclk_pin, si_pin}),
        .rst_val (3'h4),
        .q       (pins_s)
    );

    // Sync leaves reset at the idle pin levels, so no false frame or edge follows reset
    assign csn_s  = pins_s[2];
    assign sclk_s = pins_s[1];
    assign si_s   = pins_s[0];

    wire        rise      = sclk_s & ~sclk_d_r;
    wire        fall      = ~sclk_s & sclk_d_r;
    wire [7:0]  shift_nxt = {shift_r[6:0], si_s};
    wire        byte_done = rise & (bit_cnt_r == 3'h7);
    wire        is_status = (addr_r >= ADDR_STATUS_BASE);
    wire        advance   = burst_r & ~is_status;

    assign acc.wr_stb = wr_stb_r;
    assign acc.addr   = addr_r;
    assign acc.wdata  = wdata_r;

    always_ff @(posedge clk) begin
        if (!reset_n || csn_s) begin
            bit_cnt_r  <= 3'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            have_hdr_r <= 1'b0;
            read_r     <= 1'b0;
            burst_r    <= 1'b0;
            addr_r     <= 6'h00;
            load_r     <= 1'b0;
            wr_stb_r   <= 1'b0;
            wdata_r    <= 8'h00;
            so_r       <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            load_r   <= byte_done & (read_r | ~have_hdr_r);
            if (rise) begin
                shift_r   <= shift_nxt;
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (byte_done && !have_hdr_r) begin
                have_hdr_r <= 1'b1;
                read_r     <= shift_nxt[HDR_READ_BIT];
                burst_r    <= shift_nxt[HDR_BURST_BIT];
                addr_r     <= shift_nxt[5:0];
            end else if (byte_done) begin
                // Status space never takes a write
                wr_stb_r <= ~read_r & ~is_status;
                wdata_r  <= shift_nxt;
                if (advance) begin
                    addr_r <= addr_r + 6'h01;
                end
            end
            if (load_r && read_r) begin
                tx_r <= acc.rd_data;
            end else if (fall) begin
                so_r <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclk_d_r  <= 1'b0;
            so_oe_n_r <= 1'b1;
        end else begin
            sclk_d_r  <= sclk_s;
            so_oe_n_r <= csn_s;
        end
    end
endmodule : stib_spi_slave

//--- verilog/stib_sync2.sv
`timescale 1ns/1ps
module stib_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    input  wire logic [WIDTH-1:0] rst_val,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_r <= rst_val;
            q      <= rst_val;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : stib_sync2
